// ---- logic/pct_chan_counter.sv ----
/*
  One pulse channel: prescaler and two cascaded 12-bit counters.
  Assumes the pulse input is synchronous and already conditioned.
*/
`timescale 1ns/10ps
`default_nettype none
module pct_chan_counter (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_nrst, // Asynchronous reset, active low.
  input wire logic i_pulse, // Conditioned field pulse level.
  input wire logic i_accumulate, // High in accumulate mode.
  input wire logic i_gate, // Count window open.
  input wire logic i_clear, // Clear both counters.
  input wire logic i_load, // Load the preset.
  input wire logic [23:0] i_preset, // Stored preset.
  input wire logic [15:0] i_prescale, // Pair prescaler.
  output logic [23:0] o_count // Count image.
);
  pct_pkg::pct_cnt_state_t s_ff;
  pct_pkg::pct_cnt_state_t nxt_s;
  logic qual;
  logic adv;

  // The trailing edge of a pulse counts, as the inverting gate does.
  assign qual = s_ff.prev_pulse & ~i_pulse & i_gate;

  // Prescaler, cascade, clear and preset load.
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.prev_pulse = i_pulse;
    adv = 1'b0;
    if (qual)
    begin
      if (!i_accumulate || i_prescale <= pct_pkg::PRESCALE_UNIT)
        adv = 1'b1; // [RL6]
      else if (16'(s_ff.psc + pct_pkg::PRESCALE_UNIT) >= i_prescale)
      begin
        adv = 1'b1; // [RL7]
        nxt_s.psc = '0;
      end
      else
        nxt_s.psc = 16'(s_ff.psc + pct_pkg::PRESCALE_UNIT);
    end
    if (adv)
    begin
      nxt_s.low = 12'(s_ff.low + 12'h001);
      // The upper counter steps on the falling edge of the lower top bit.
      if (s_ff.low[11] && !nxt_s.low[11])
        nxt_s.high = 12'(s_ff.high + 12'h001); // [RL19]
    end
    if (i_clear)
    begin
      nxt_s.low = '0;
      nxt_s.high = '0;
      nxt_s.psc = '0;
    end
    else if (i_load && i_accumulate)
    begin
      {nxt_s.high, nxt_s.low} = i_preset; // [RL2] [RL3]
      nxt_s.psc = '0;
    end
  end

  // State register.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  // Rate mode reports only the lower counter.
  assign o_count = i_accumulate ? {s_ff.high, s_ff.low} : {pct_pkg::IMAGE_PAD, s_ff.low};

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  preset_load_a: assert property ( // [RL2]
    i_accumulate && i_load && !i_clear |=> {s_ff.high, s_ff.low} == $past(i_preset))
    else $error("preset not loaded as starting count");
  rate_ignore_a: assert property ( // [RL3]
    !i_accumulate && i_load && !i_clear && !qual |=> $stable({s_ff.high, s_ff.low}))
    else $error("preset used in rate mode");
  unit_step_a: assert property ( // [RL6]
    i_accumulate && i_prescale <= 16'h0001 && qual && !i_clear && !i_load
      |=> s_ff.low == 12'($past(s_ff.low) + 12'h001))
    else $error("count did not step on each pulse");
  prescale_hold_a: assert property ( // [RL7]
    i_accumulate && i_prescale > 16'h0001 && qual && !i_clear && !i_load
      && 16'(s_ff.psc + 16'h0001) < i_prescale |=> $stable(s_ff.low))
    else $error("count stepped before prescale reached");
  cascade_step_a: assert property ( // [RL19]
    s_ff.low == 12'h000 && $past(s_ff.low) == 12'hfff && !$past(i_clear)
      && !$past(i_load) |-> s_ff.high == 12'($past(s_ff.high) + 12'h001))
    else $error("upper counter missed lower wrap");
endmodule : pct_chan_counter
`default_nettype wire

// ---- logic/pct_tuning_entry.sv ----
/*
  Operator tuning entry, rate windows, display and register port of a
  four-channel pulse input board.
  Assumes switches and buttons are debounced and synchronous to the clock,
  and that the interval expiry arrives as a one-cycle pulse per pair.
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// RL1: Positions 9 to C edit channel presets.
// RL2: Accumulate mode loads preset as starting count.
// RL3: Rate mode ignores the preset.
// RL4: Positions D, E edit prescaler or rate.
// RL5: One prescaler per channel pair.
// RL6: Prescale zero or one counts every pulse.
// RL7: Prescale N counts once per N pulses.
// RL8: Select after prescale adjust stores it.
// RL9: First select shows default counter size.
// RL10: Up or down toggles 8/12 bit size.
// RL11: Second select shows rate, default 512.
// RL12: Twelve-bit rate steps up, 512 to 20000.
// RL13: Eight-bit rate kept within 50 to 10000.
// RL14: Further select stores size and rate.
// RL15: Eight-character display shows status and editing.
// RL16: Normal display shows value at selected position.
// RL17: Counts reported as 12 or 24 bit.
// RL18: Start sets window latch, expiry clears it.
// RL19: Lower counter top bit fall steps upper.
// RL20: Rate holds at upper limit on up.
module pct_tuning_entry (
  input wire logic i_clk_sys, // System clock, 40 MHz.
  input wire logic i_nrst, // Asynchronous reset, active low.
  input wire logic i_tuning_mode, // High while the board is in tuning.
  input wire logic [3:0] i_rotary_position_selector, // Rotary position.
  input wire pct_pkg::pct_buttons_t i_buttons, // Select, up, down levels.
  input wire logic [1:0] i_rate_mode, // Slide switch per pair, high is rate.
  input wire logic [3:0] i_pulse, // Conditioned field pulses.
  input wire logic [1:0] i_interval_expire, // Interval end pulse per pair.
  input wire pct_pkg::pct_bus_req_t i_bus, // Register strobes, address, data.
  output logic [31:0] o_rdata, // Read data, one cycle after the strobe.
  output logic [63:0] o_status_text_display, // Eight ASCII characters.
  output logic o_pair_a_count_window, // Count window, channels 1 and 2.
  output logic o_pair_b_count_window // Count window, channels 3 and 4.
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  pct_pkg::pct_main_state_t s_ff;
  pct_pkg::pct_main_state_t nxt_s;
  pct_pkg::pct_buttons_t edge_btn;
  logic [3:0] pos;
  logic stay;
  logic ctrl_wr;
  logic [1:0] pair_window_start;
  logic [1:0] pair_clear;
  logic [1:0] pidx;
  logic ppair;
  logic [3:0][23:0] count_image;
  logic [15:0] rate_min;
  logic [15:0] rate_max;

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    if (v < 4'ha)
      return 8'(pct_pkg::ASCII_ZERO + {4'h0, v});
    return 8'(pct_pkg::ASCII_LETTER_BASE + {4'h0, v});
  endfunction : hex_char

  function automatic logic [63:0] show_value(input logic [7:0] tag,
                                             input logic [23:0] v);
    return {tag, pct_pkg::ASCII_SPACE, hex_char(v[23:20]), hex_char(v[19:16]),
            hex_char(v[15:12]), hex_char(v[11:8]), hex_char(v[7:4]),
            hex_char(v[3:0])};
  endfunction : show_value

  // ****************************************************************
  // Input decode
  // ****************************************************************
  // Buttons act on their press edge only, so a held button repeats nothing.
  assign pos = i_rotary_position_selector;
  assign edge_btn = i_buttons & ~s_ff.btn_prev;
  assign stay = i_tuning_mode && pos == s_ff.edit_pos;
  assign pidx = 2'(pos - pct_pkg::POS_PRESET_FIRST);
  assign ppair = 1'(pos - pct_pkg::POS_PAIR_FIRST);
  assign ctrl_wr = i_bus.wr && i_bus.addr == pct_pkg::REG_CTRL;
  assign pair_window_start = ctrl_wr ? i_bus.wdata[pct_pkg::CTRL_START_LSB +: 2] : 2'h0;
  // The clear only reaches the counters of a pair in rate mode.
  assign pair_clear = ctrl_wr ? (i_bus.wdata[pct_pkg::CTRL_CLEAR_LSB +: 2] & i_rate_mode)
                              : 2'h0;
  // Active rate range follows the size being edited.
  assign rate_min = s_ff.edit_size ? pct_pkg::RATE12_MIN : pct_pkg::RATE8_MIN;
  assign rate_max = s_ff.edit_size ? pct_pkg::RATE12_MAX : pct_pkg::RATE8_MAX;

  // ****************************************************************
  // Channel counters
  // ****************************************************************
  // Each counter is gated by its pair window in rate mode only.
  for (genvar ch = 0; ch < pct_pkg::CHANNELS; ch++)
  begin : g_chan
    pct_chan_counter u_cnt (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_pulse(i_pulse[ch]),
      .i_accumulate(!i_rate_mode[ch / 2]),
      .i_gate(!i_rate_mode[ch / 2] || s_ff.window[ch / 2]), // [RL18]
      .i_clear(pair_clear[ch / 2]),
      .i_load(s_ff.load[ch]),
      .i_preset(s_ff.preset[ch]),
      .i_prescale(s_ff.prescale[ch / 2]), // [RL5]
      .o_count(count_image[ch]) // [RL17]
    );
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Tuning sequence, window latches, display text and register reads.
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.btn_prev = i_buttons;
    nxt_s.load = 4'h0;
    nxt_s.rate_prev = i_rate_mode;
    // A pair returning to accumulate restarts from its presets.
    for (int p = 0; p < pct_pkg::PAIRS; p++)
    begin
      if (s_ff.rate_prev[p] && !i_rate_mode[p])
        nxt_s.load[2 * p +: 2] = 2'h3; // [RL2]
      // Set beats a same-cycle expiry so a new window is never lost.
      nxt_s.window[p] = pair_window_start[p]
                        || (s_ff.window[p] && !i_interval_expire[p]); // [RL18]
    end
    unique case (s_ff.fsm)
      pct_pkg::ST_IDLE:
      begin
        if (i_tuning_mode && edge_btn.select)
        begin
          nxt_s.edit_pos = pos;
          if (pos >= pct_pkg::POS_PRESET_FIRST && pos <= pct_pkg::POS_PRESET_LAST)
          begin
            nxt_s.edit_idx = pidx;
            nxt_s.edit_val = s_ff.preset[pidx];
            nxt_s.fsm = pct_pkg::ST_EDIT_PRESET; // [RL1]
          end
          else if (pos >= pct_pkg::POS_PAIR_FIRST && pos <= pct_pkg::POS_PAIR_LAST)
          begin
            nxt_s.edit_idx = {1'b0, ppair};
            if (i_rate_mode[ppair])
            begin
              nxt_s.edit_size = pct_pkg::SIZE_DEFAULT; // [RL9]
              nxt_s.fsm = pct_pkg::ST_SHOW_SIZE; // [RL4]
            end
            else
            begin
              nxt_s.edit_val = {8'h00, s_ff.prescale[ppair]};
              nxt_s.fsm = pct_pkg::ST_EDIT_PRESCALE; // [RL4]
            end
          end
        end
      end
      pct_pkg::ST_EDIT_PRESET:
      begin
        if (edge_btn.increment)
          nxt_s.edit_val = 24'(s_ff.edit_val + 24'h000001);
        else if (edge_btn.decrement_button)
          nxt_s.edit_val = 24'(s_ff.edit_val - 24'h000001);
        if (edge_btn.select)
        begin
          nxt_s.preset[s_ff.edit_idx] = s_ff.edit_val;
          nxt_s.load[s_ff.edit_idx] = 1'b1; // [RL2]
          nxt_s.fsm = pct_pkg::ST_IDLE;
        end
      end
      pct_pkg::ST_EDIT_PRESCALE:
      begin
        if (edge_btn.increment)
          nxt_s.edit_val[15:0] = 16'(s_ff.edit_val[15:0] + 16'h0001);
        else if (edge_btn.decrement_button)
          nxt_s.edit_val[15:0] = 16'(s_ff.edit_val[15:0] - 16'h0001);
        if (edge_btn.select)
        begin
          nxt_s.prescale[s_ff.edit_idx[0]] = s_ff.edit_val[15:0]; // [RL8] [RL5]
          nxt_s.fsm = pct_pkg::ST_IDLE;
        end
      end
      pct_pkg::ST_SHOW_SIZE:
      begin
        if (edge_btn.increment || edge_btn.decrement_button)
          nxt_s.edit_size = !s_ff.edit_size; // [RL10]
        if (edge_btn.select)
        begin
          nxt_s.edit_val = {8'h00, pct_pkg::RATE_DEFAULT}; // [RL11]
          nxt_s.fsm = pct_pkg::ST_SHOW_RATE;
        end
      end
      pct_pkg::ST_SHOW_RATE:
      begin
        // Steps saturate at the active limits; the default lies in both ranges.
        if (edge_btn.increment)
        begin
          if (s_ff.edit_val[15:0] >= 16'(rate_max - pct_pkg::RATE_STEP))
            nxt_s.edit_val[15:0] = rate_max; // [RL20] [RL12] [RL13]
          else
            nxt_s.edit_val[15:0] = 16'(s_ff.edit_val[15:0] + pct_pkg::RATE_STEP); // [RL12]
        end
        else if (edge_btn.decrement_button)
        begin
          if (s_ff.edit_val[15:0] <= 16'(rate_min + pct_pkg::RATE_STEP))
            nxt_s.edit_val[15:0] = rate_min; // [RL13]
          else
            nxt_s.edit_val[15:0] = 16'(s_ff.edit_val[15:0] - pct_pkg::RATE_STEP);
        end
        if (edge_btn.select)
        begin
          nxt_s.ratecfg[s_ff.edit_idx[0]] = {s_ff.edit_size, s_ff.edit_val[15:0]}; // [RL14]
          nxt_s.fsm = pct_pkg::ST_IDLE;
        end
      end
    endcase
    // Leaving tuning or turning the selector abandons an unsaved edit.
    if (s_ff.fsm != pct_pkg::ST_IDLE && !stay)
      nxt_s.fsm = pct_pkg::ST_IDLE;

    // Display follows the editing state, else the stored value at the position.
    unique case (s_ff.fsm)
      pct_pkg::ST_EDIT_PRESET: nxt_s.display = show_value("p", s_ff.edit_val); // [RL15]
      pct_pkg::ST_EDIT_PRESCALE: nxt_s.display = show_value("s", s_ff.edit_val);
      pct_pkg::ST_SHOW_SIZE:
        nxt_s.display = s_ff.edit_size ? pct_pkg::TXT_SIZE12 : pct_pkg::TXT_SIZE8;
      pct_pkg::ST_SHOW_RATE: nxt_s.display = show_value("r", s_ff.edit_val);
      pct_pkg::ST_IDLE:
      begin
        if (pos <= pct_pkg::POS_COUNT_LAST)
          nxt_s.display = show_value("C", count_image[pos[1:0]]); // [RL16]
        else if (pos <= pct_pkg::POS_PRESET_VIEW_LAST)
          nxt_s.display = show_value("P", s_ff.preset[pos[1:0]]);
        else if (pos == pct_pkg::POS_PRESCALE_VIEW)
          nxt_s.display = show_value("S", {s_ff.prescale[1][11:0], s_ff.prescale[0][11:0]});
        else if (pos <= pct_pkg::POS_PRESET_LAST)
          nxt_s.display = show_value("P", s_ff.preset[pidx]);
        else if (pos <= pct_pkg::POS_PAIR_LAST && i_rate_mode[ppair])
          nxt_s.display = show_value("R", {7'h00, s_ff.ratecfg[ppair]});
        else if (pos <= pct_pkg::POS_PAIR_LAST)
          nxt_s.display = show_value("S", {8'h00, s_ff.prescale[ppair]});
        else
          nxt_s.display = pct_pkg::TXT_BLANK;
      end
    endcase

    // Read data stand one cycle only; unmapped addresses read zero.
    nxt_s.rdata = 32'h0;
    if (i_bus.rd)
    begin
      if (i_bus.addr == pct_pkg::REG_STATUS)
        nxt_s.rdata = {24'h0, ~i_rate_mode[1], ~i_rate_mode[1], ~i_rate_mode[0],
                       ~i_rate_mode[0], i_rate_mode, s_ff.window}; // [RL17]
      for (int c = 0; c < pct_pkg::CHANNELS; c++)
      begin
        if (i_bus.addr == 8'(pct_pkg::REG_COUNT0 + 8'(c * 4)))
          nxt_s.rdata = {8'h00, count_image[c]};
        if (i_bus.addr == 8'(pct_pkg::REG_PRESET0 + 8'(c * 4)))
          nxt_s.rdata = {8'h00, s_ff.preset[c]};
      end
      for (int p = 0; p < pct_pkg::PAIRS; p++)
      begin
        if (i_bus.addr == 8'(pct_pkg::REG_PRESCALE0 + 8'(p * 4)))
          nxt_s.rdata = {16'h0, s_ff.prescale[p]};
        if (i_bus.addr == 8'(pct_pkg::REG_RATECFG0 + 8'(p * 4)))
          nxt_s.rdata = {15'h0, s_ff.ratecfg[p]};
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Stored tuning starts from the documented defaults after reset.
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_ff <= '0;
      s_ff.ratecfg <= {2{pct_pkg::RATECFG_RST}};
      s_ff.display <= pct_pkg::TXT_BLANK;
    end
    else
      s_ff <= nxt_s;
  end

  assign o_rdata = s_ff.rdata;
  assign o_status_text_display = s_ff.display;
  assign o_pair_a_count_window = s_ff.window[0];
  assign o_pair_b_count_window = s_ff.window[1];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence size_shown_s;
    s_ff.fsm == pct_pkg::ST_SHOW_SIZE && stay && edge_btn.select;
  endsequence
  sequence rate_saved_s;
    s_ff.fsm == pct_pkg::ST_SHOW_RATE && stay && edge_btn.select;
  endsequence

  preset_entry_a: assert property ( // [RL1]
    s_ff.fsm == pct_pkg::ST_IDLE && i_tuning_mode && edge_btn.select
      && pos >= 4'h9 && pos <= 4'hc |=> s_ff.fsm == pct_pkg::ST_EDIT_PRESET)
    else $error("preset edit not entered");
  pair_entry_a: assert property ( // [RL4] [RL9]
    s_ff.fsm == pct_pkg::ST_IDLE && i_tuning_mode && edge_btn.select
      && (pos == 4'hd || pos == 4'he) && i_rate_mode[ppair]
      |=> s_ff.fsm == pct_pkg::ST_SHOW_SIZE && s_ff.edit_size)
    else $error("rate entry did not show default size");
  prescale_store_a: assert property ( // [RL8]
    s_ff.fsm == pct_pkg::ST_EDIT_PRESCALE && stay && edge_btn.select
      |=> s_ff.prescale[s_ff.edit_idx[0]] == $past(s_ff.edit_val[15:0]))
    else $error("prescale not stored");
  size_toggle_a: assert property ( // [RL10]
    s_ff.fsm == pct_pkg::ST_SHOW_SIZE && stay && edge_btn.increment
      |=> s_ff.edit_size != $past(s_ff.edit_size))
    else $error("size did not toggle");
  rate_default_a: assert property ( // [RL11]
    size_shown_s |=> s_ff.fsm == pct_pkg::ST_SHOW_RATE && s_ff.edit_val == 24'h000200)
    else $error("rate default not shown");
  rate_range_a: assert property ( // [RL12] [RL13]
    s_ff.fsm == pct_pkg::ST_SHOW_RATE && $past(s_ff.fsm) == pct_pkg::ST_SHOW_RATE
      |-> s_ff.edit_val[15:0] >= rate_min && s_ff.edit_val[15:0] <= rate_max)
    else $error("rate outside active range");
  rate_hold_a: assert property ( // [RL20]
    s_ff.fsm == pct_pkg::ST_SHOW_RATE && stay && edge_btn.increment
      && !edge_btn.select && s_ff.edit_val[15:0] == rate_max |=> $stable(s_ff.edit_val))
    else $error("rate moved past upper limit");
  rate_store_a: assert property ( // [RL14]
    rate_saved_s |=> s_ff.ratecfg[s_ff.edit_idx[0]].max_rate == $past(s_ff.edit_val[15:0])
      && s_ff.ratecfg[s_ff.edit_idx[0]].size_twelve_bit == $past(s_ff.edit_size))
    else $error("rate parameters not stored");
  window_set_a: assert property ( // [RL18]
    pair_window_start[0] |=> o_pair_a_count_window ##1 (o_pair_a_count_window
      || $past(i_interval_expire[0])))
    else $error("window latch not set");
  window_clear_a: assert property ( // [RL18]
    i_interval_expire[1] && !pair_window_start[1] |=> !o_pair_b_count_window)
    else $error("window latch not cleared");
endmodule : pct_tuning_entry
`default_nettype wire

// ---- pkg/pct_pkg.sv ----
/*
  Shared constants and types of the pulse counter tuning block.
  Assumes one 40 MHz system clock and synchronous operator switches.
*/
`default_nettype none
package pct_pkg;
  // ****************************************************************
  // Sizes and rotary positions
  // ****************************************************************
  localparam int CHANNELS = 4;
  localparam int PAIRS = 2;
  localparam logic [3:0] POS_COUNT_LAST = 4'h3;
  localparam logic [3:0] POS_PRESET_VIEW_LAST = 4'h7;
  localparam logic [3:0] POS_PRESCALE_VIEW = 4'h8;
  localparam logic [3:0] POS_PRESET_FIRST = 4'h9;
  localparam logic [3:0] POS_PRESET_LAST = 4'hc;
  localparam logic [3:0] POS_PAIR_FIRST = 4'hd;
  localparam logic [3:0] POS_PAIR_LAST = 4'he;
  // ****************************************************************
  // Tuning values and limits (Hz)
  // ****************************************************************
  localparam logic [15:0] RATE_DEFAULT = 16'h0200;
  localparam logic [15:0] RATE12_MIN = 16'h0200;
  localparam logic [15:0] RATE12_MAX = 16'h4e20;
  localparam logic [15:0] RATE8_MIN = 16'h0032;
  localparam logic [15:0] RATE8_MAX = 16'h2710;
  localparam logic [15:0] RATE_STEP = 16'h0040;
  localparam logic SIZE_DEFAULT = 1'b1;
  localparam logic [15:0] PRESCALE_UNIT = 16'h0001;
  localparam logic [11:0] IMAGE_PAD = 12'h000;
  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT0 = 8'h08;
  localparam logic [7:0] REG_PRESET0 = 8'h18;
  localparam logic [7:0] REG_PRESCALE0 = 8'h28;
  localparam logic [7:0] REG_RATECFG0 = 8'h30;
  localparam logic [7:0] REG_STRIDE = 8'h04;
  localparam int CTRL_START_LSB = 0;
  localparam int CTRL_CLEAR_LSB = 2;
  // ****************************************************************
  // Display text
  // ****************************************************************
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_LETTER_BASE = 8'h37;
  localparam logic [7:0] ASCII_SPACE = 8'h20;
  localparam logic [63:0] TXT_BLANK = "        ";
  localparam logic [63:0] TXT_SIZE8 = "SZ  8BIT";
  localparam logic [63:0] TXT_SIZE12 = "SZ 12BIT";
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic select;
    logic increment;
    logic decrement_button;
  } pct_buttons_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pct_bus_req_t;
  typedef struct packed {
    logic size_twelve_bit;
    logic [15:0] max_rate;
  } pct_rate_cfg_t;
  localparam pct_rate_cfg_t RATECFG_RST = '{SIZE_DEFAULT, RATE_DEFAULT};
  typedef enum logic [2:0] {
    ST_IDLE, ST_EDIT_PRESET, ST_EDIT_PRESCALE, ST_SHOW_SIZE, ST_SHOW_RATE
  } pct_tune_state_t;
  typedef struct packed {
    logic prev_pulse;
    logic [15:0] psc;
    logic [11:0] low;
    logic [11:0] high;
  } pct_cnt_state_t;
  typedef struct packed {
    pct_tune_state_t fsm;
    pct_buttons_t btn_prev;
    logic [3:0][23:0] preset;
    logic [1:0][15:0] prescale;
    pct_rate_cfg_t [1:0] ratecfg;
    logic [1:0] window;
    logic [1:0] rate_prev;
    logic [23:0] edit_val;
    logic edit_size;
    logic [1:0] edit_idx;
    logic [3:0] edit_pos;
    logic [3:0] load;
    logic [63:0] display;
    logic [31:0] rdata;
  } pct_main_state_t;
endpackage : pct_pkg
`default_nettype wire

// ---- test/pct_operator.sv ----
/* Operator model: rotary selector and three buttons.
   Assumes the bench clock; presses are released before the next one. */
`timescale 1ns/10ps
`default_nettype none
module pct_operator (
  input wire logic i_clk_sys, // Bench clock.
  output var logic [3:0] o_pos, // Rotary position.
  output var pct_pkg::pct_buttons_t o_btn // Button levels.
);
  initial o_pos = 4'h0;
  initial o_btn = '0;
  // A hand never presses twice without a release, so a rise is always seen.
  task automatic press(input int b);
    @(posedge i_clk_sys) o_btn[b] <= 1'b1;
    @(posedge i_clk_sys) o_btn <= '0;
    repeat (2) @(posedge i_clk_sys);
  endtask : press
endmodule : pct_operator
`default_nettype wire

// ---- test/testbench.sv ----
/* Self-checking bench of the tuning block.
   Assumes the operator model beside it and a 40 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_clk_sys, i_nrst, tun;
  logic [1:0] rm, ex;
  logic [3:0] pul, pos;
  pct_pkg::pct_buttons_t btn;
  pct_pkg::pct_bus_req_t bus;
  logic [31:0] rd;
  logic [63:0] disp;
  logic wa, wb;
  int fails, comparisons;
  pct_tuning_entry dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_tuning_mode(tun),
    .i_rotary_position_selector(pos), .i_buttons(btn), .i_rate_mode(rm), .i_pulse(pul),
    .i_interval_expire(ex), .i_bus(bus), .o_rdata(rd), .o_status_text_display(disp),
    .o_pair_a_count_window(wa), .o_pair_b_count_window(wb));
  pct_operator op (.i_clk_sys(i_clk_sys), .o_pos(pos), .o_btn(btn));
  // Clock and a watchdog sized well above the longest scenario.
  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    #500000;
    fails++;
    end_sim();
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys) bus <= '{1'b1, 1'b0, a, d};
    @(posedge i_clk_sys) bus <= '0;
  endtask : bw
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic br(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge i_clk_sys) bus <= '0;
    #1 chk("rdata", {32'h0, e}, {32'h0, rd});
  endtask : br
  // A count happens on the falling side of each pulse.
  task automatic pulses(input logic [3:0] m, input int n);
    repeat (n)
    begin
      @(posedge i_clk_sys) pul <= m;
      @(posedge i_clk_sys) pul <= 4'h0;
    end
  endtask : pulses
  task automatic t_preset;
    op.o_pos <= 4'h9;
    op.press(2);
    chk("disp", 64'h70, {56'h0, disp[63:56]});
    repeat (3) op.press(1);
    op.press(2);
    br(pct_pkg::REG_PRESET0, 32'h3);
    br(pct_pkg::REG_COUNT0, 32'h3);
    chk("disp", "P 000003", disp);
    // An edit dropped by leaving tuning must store nothing.
    op.press(2);
    op.press(0);
    op.press(0);
    chk("disp", "p 000001", disp);
    tun <= 1'b0;
    br(pct_pkg::REG_PRESET0, 32'h3);
    tun <= 1'b1;
  endtask : t_preset
  task automatic t_prescale;
    op.o_pos <= 4'hd;
    op.press(2);
    repeat (3) op.press(1);
    op.press(2);
    br(pct_pkg::REG_PRESCALE0, 32'h3);
    br(pct_pkg::REG_PRESCALE0 + 8'h04, 32'h0);
    pulses(4'h5, 6);
    br(pct_pkg::REG_COUNT0, 32'h5);
    br(pct_pkg::REG_COUNT0 + 8'h08, 32'h6);
  endtask : t_prescale
  task automatic t_rate;
    rm <= 2'b01;
    op.press(2);
    chk("disp", pct_pkg::TXT_SIZE12, disp);
    op.press(1);
    chk("disp", pct_pkg::TXT_SIZE8, disp);
    op.press(2);
    repeat (160) op.press(1);
    op.press(2);
    br(pct_pkg::REG_RATECFG0, 32'h2710);
    op.press(2);
    op.press(2);
    op.press(1);
    op.press(1);
    op.press(0);
    op.press(2);
    br(pct_pkg::REG_RATECFG0, 32'h10240);
  endtask : t_rate
  task automatic t_window;
    bw(pct_pkg::REG_CTRL, 32'h1);
    #1 chk("window", 64'h1, {63'h0, wa});
    @(posedge i_clk_sys) ex <= 2'b01;
    @(posedge i_clk_sys) ex <= 2'b00;
    #1 chk("window", 64'h0, {63'h0, wa});
    // Both pairs in rate mode: clear both pairs, open only pair b's window.
    rm <= 2'b11;
    bw(pct_pkg::REG_CTRL, 32'he);
    br(pct_pkg::REG_STATUS, 32'he);
    pulses(4'hf, 3);
    br(pct_pkg::REG_COUNT0 + 8'h08, 32'h3);
    br(pct_pkg::REG_COUNT0, 32'h0);
    op.o_pos <= 4'hb;
    op.press(2);
    op.press(1);
    op.press(2);
    br(pct_pkg::REG_COUNT0 + 8'h08, 32'h3);
    @(posedge i_clk_sys) ex <= 2'b10;
    @(posedge i_clk_sys) ex <= 2'b00;
    #1 chk("window", 64'h0, {63'h0, wb});
    // Back to accumulate: the pair restarts from its presets two cycles later.
    rm <= 2'b00;
    @(posedge i_clk_sys);
    br(pct_pkg::REG_COUNT0 + 8'h08, 32'h1);
  endtask : t_window
  task automatic end_sim;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // Reset for three cycles, then the scenarios in turn.
  initial
  begin
    {i_nrst, tun, rm, ex, pul, bus} = '0;
    repeat (3) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    tun <= 1'b1;
    br(pct_pkg::REG_RATECFG0, 32'h10200);
    br(8'hfc, 32'h0);
    t_preset();
    t_prescale();
    t_rate();
    t_window();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
